// ### sbsp_defs.svh
// timing counts, field codes and reset values of the serial port
// assumes the 10 MHz core clock and the package sbsp_pkg beside it
`ifndef SBSP_DEFS_SVH
`define SBSP_DEFS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SBSP_CLK_NS 100
`define SBSP_SCLK_HALF_NS 400
`define SBSP_HALF_CYC ((`SBSP_SCLK_HALF_NS + `SBSP_CLK_NS - 1) / `SBSP_CLK_NS)
`define SBSP_GAP_HALVES 4

// ----------------------------------------------------------------
// field positions and codes
// ----------------------------------------------------------------
`define SBSP_CS_ON_BIT 1
`define SBSP_CS_DELAY_BIT 0
`define SBSP_WL_8 3'h0
`define SBSP_WL_12 3'h1
`define SBSP_WL_16 3'h2
`define SBSP_WL_20 3'h3
`define SBSP_WL_24 3'h4
`define SBSP_WL_32 3'h5
`define SBSP_PCM_LAST 4'hf

// ----------------------------------------------------------------
// sizes and reset values
// ----------------------------------------------------------------
`define SBSP_DATA_W 32
`define SBSP_FIFO_DEPTH 8
`define SBSP_SLOT_RST 10'h3ff

`endif

// ### sbsp_pkg.sv
// types and decode functions shared by the serial port files
// assumes nothing beyond a SystemVerilog compiler
package sbsp_pkg;

  // ----------------------------------------------------------------
  // configuration carried as one group
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pcm_bitmask_enable;
    logic [1:0] clock_stop_select;
    logic tx_clock_polarity;
    logic rx_clock_polarity;
    logic tx_clock_direction;
    logic [2:0] tx_word_length;
    logic [2:0] rx_word_length;
  } sbsp_cfg_s;

  // master sequencer states
  typedef enum logic [2:0] {
    m_idle,
    m_setup,
    m_run,
    m_hold,
    m_gap
  } sbsp_mst_e;

  // ----------------------------------------------------------------
  // decode functions
  // ----------------------------------------------------------------
  // word length code to bits
  function automatic logic [5:0] sbsp_word_bits(input logic [2:0] code);
    case (code)
      3'h0: sbsp_word_bits = 6'h08;
      3'h1: sbsp_word_bits = 6'h0c;
      3'h2: sbsp_word_bits = 6'h10;
      3'h3: sbsp_word_bits = 6'h14;
      3'h4: sbsp_word_bits = 6'h18;
      3'h5: sbsp_word_bits = 6'h20;
      default: sbsp_word_bits = 6'h10;
    endcase
  endfunction

  // enable bit of a slot, blocks of 16 alternate a and b
  function automatic logic sbsp_mask_bit(input logic [15:0] a,
                                         input logic [15:0] b,
                                         input logic [9:0] slot);
    sbsp_mask_bit = slot[4] ? b[slot[3:0]] : a[slot[3:0]];
  endfunction

endpackage

// ### sbsp_fifo.sv
// small synchronous fifo with valid and ready on both sides
// assumes depth is a power of two and one clock for both sides
`timescale 1ns/1ns
module sbsp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic ready_reg;
  wire push = in_valid_in & ready_reg;
  wire pop = out_valid_out & out_ready_in;

  // ----------------------------------------------------------------
  // status and read side
  // ----------------------------------------------------------------
  assign count_next = count_reg + CW'(push) - CW'(pop);
  assign out_valid_out = (count_reg != '0);
  assign out_data_out = mem[rd_ptr_reg];
  assign in_ready_out = ready_reg;

  // storage, no reset needed on data
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_in;
    end
  end

  // pointers, count and registered ready
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + AW'(push);
      rd_ptr_reg <= rd_ptr_reg + AW'(pop);
      count_reg <= count_next;
      ready_reg <= (count_next != CW'(DEPTH));
    end
  end
endmodule

// ### sbsp_top.sv
// serial port: bit-masked pcm framing and clock-stop spi master/slave
// assumes pins are asynchronous to clk_in and a slow link clock
// How it works
// - pcm receive drops bits whose slot is not enabled
// - after 16 enabled bits the word goes out with a receive pulse
// - receive pattern alternates enable a and b every 16 clocks
// - pcm transmit drives only enabled slots, otherwise floats the pin
// - transmit pattern alternates enable a and b every 16 clocks
// - transmit pulse after every 16 enabled bits sent
// - clock-stop uses transmit clock and frame sync for the receiver
// - transmit clock pin is spi clock, transmit sync pin is select
// - stop select 0x runs normally, 10 no delay, 11 half-cycle delay
// - direction bit: clock pin input as slave, driven as master
// - 10, idle low: launch on rising, sample on falling
// - 11, idle low: launch half cycle early, sample on rising
// - 10, idle high: launch on falling, sample on rising
// - 11, idle high: launch half cycle early, sample on falling
// - select stays active for the whole packet
// - packet length 8, 12, 16, 20, 24 or 32 bits
// - clock stops and select drops after each packet
// - serial in takes miso as master, mosi as slave
// - pcm mode when its enable is set and stop select is 0x, frames up to 1024 bits
`timescale 1ns/1ns
`include "sbsp_defs.svh"
module sbsp_top import sbsp_pkg::*; (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire sbsp_cfg_s cfg_in,
  input wire logic [15:0] rx_bit_enable_a_in,
  input wire logic [15:0] rx_bit_enable_b_in,
  input wire logic [15:0] tx_bit_enable_a_in,
  input wire logic [15:0] tx_bit_enable_b_in,
  input wire logic [31:0] tx_data_word_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  output logic [31:0] rx_data_word_out,
  output logic rx_valid_out,
  output logic tx_irq_out,
  input wire logic serial_in_pin_in,
  output logic serial_out_pin_out,
  output logic serial_out_pin_oe_out,
  input wire logic tx_clock_pin_in,
  output logic tx_clock_pin_out,
  output logic tx_clock_pin_oe_out,
  input wire logic tx_frame_sync_pin_in,
  output logic tx_frame_sync_pin_out,
  output logic tx_frame_sync_pin_oe_out,
  input wire logic rx_clock_pin_in,
  input wire logic rx_frame_sync_pin_in
);
  logic [4:0] sync1_reg, sync2_reg, pin_d_reg;
  logic cs_lvl_d_reg, sclk_pin_reg, sclk_pin_next;
  sbsp_mst_e mst_state_reg, mst_next;
  logic [7:0] half_cnt_reg, half_next;
  logic [6:0] edge_cnt_reg, edge_next;
  logic [31:0] tx_shift_reg, tx_shift_next, rx_shift_reg, rx_shift_next;
  logic [3:0] tx_bits_reg, tx_bits_next;
  logic [5:0] rx_bits_reg, rx_bits_next;
  logic [9:0] tx_slot_reg, tx_slot_next, rx_slot_reg, rx_slot_next;
  logic sout_reg, sout_next, soe_reg, soe_next;
  logic tx_irq_reg, tx_irq_next, rx_valid_reg, rx_valid_next;
  logic [31:0] rx_data_reg, rx_data_next;
  logic fs_out_reg, fs_oe_reg, clk_oe_reg, fifo_pop;
  logic [31:0] fifo_data;
  logic fifo_valid;

  // ----------------------------------------------------------------
  // data buffer in front of the transmitter
  // ----------------------------------------------------------------
  sbsp_fifo #(.WIDTH(`SBSP_DATA_W), .DEPTH(`SBSP_FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .in_data_in(tx_data_word_in),
    .in_valid_in(tx_valid_in),
    .in_ready_out(tx_ready_out),
    .out_data_out(fifo_data),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_pop)
  );

  // two-stage synchronisers, then one stage for edge finding
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      // clocks rest low, syncs and data high: no false edge on release
      sync1_reg <= 5'h1a;
      sync2_reg <= 5'h1a;
      pin_d_reg <= 5'h1a;
    end else begin
      sync1_reg <= {serial_in_pin_in, rx_frame_sync_pin_in,
                    rx_clock_pin_in, tx_frame_sync_pin_in, tx_clock_pin_in};
      sync2_reg <= sync1_reg;
      pin_d_reg <= sync2_reg;
    end
  end

  // ----------------------------------------------------------------
  // mode decode and edge detection
  // ----------------------------------------------------------------
  wire tclk_s = sync2_reg[0];
  wire tfs_act = ~sync2_reg[1];
  wire din_s = sync2_reg[4];
  wire cs_on = cfg_in.clock_stop_select[`SBSP_CS_ON_BIT];
  wire cs_delay = cfg_in.clock_stop_select[`SBSP_CS_DELAY_BIT];
  wire master = cs_on & cfg_in.tx_clock_direction;
  wire pcm_on = cfg_in.pcm_bitmask_enable & ~cs_on;
  wire [5:0] tx_len = sbsp_word_bits(cfg_in.tx_word_length);
  wire [5:0] rx_len = sbsp_word_bits(cfg_in.rx_word_length);
  // receiver clock taken from the transmit clock in clock-stop
  wire cs_lvl = (master ? sclk_pin_reg : tclk_s)
                ^ cfg_in.tx_clock_polarity;
  wire cs_lead = cs_lvl & ~cs_lvl_d_reg;
  wire cs_trail = ~cs_lvl & cs_lvl_d_reg;
  wire cs_launch = cs_delay ? cs_trail : cs_lead;
  wire cs_sample = cs_delay ? cs_lead : cs_trail;
  wire mst_go = master & (mst_state_reg == m_idle) & fifo_valid;
  wire mst_frame = (mst_state_reg == m_setup) | (mst_state_reg == m_run)
                   | (mst_state_reg == m_hold);
  // slave select is the transmit sync pin, active low
  wire slv_start = ~sync2_reg[1] & pin_d_reg[1];
  wire cs_frame = master ? mst_frame : tfs_act;
  wire cs_start = master ? mst_go : slv_start;
  wire tick = (half_cnt_reg == 8'h00);
  wire [6:0] edge_last = 7'({tx_len, 1'b0}) - 7'h01;
  wire [31:0] tx_word = fifo_valid ? fifo_data : 32'h0000_0000;
  wire [31:0] tx_aligned = tx_word << (6'h20 - tx_len);
  // pcm edges: transmit on leading, receive on trailing edge
  wire tlvl = tclk_s ^ cfg_in.tx_clock_polarity;
  wire tlvl_d = pin_d_reg[0] ^ cfg_in.tx_clock_polarity;
  wire rlvl = sync2_reg[2] ^ cfg_in.rx_clock_polarity;
  wire rlvl_d = pin_d_reg[2] ^ cfg_in.rx_clock_polarity;
  wire pcm_tx_ev = tlvl & ~tlvl_d;
  wire pcm_rx_ev = ~rlvl & rlvl_d;
  wire rfs_act = ~sync2_reg[3];
  wire [9:0] tx_slot_now = tfs_act ? 10'h000 : tx_slot_reg + 10'h001;
  wire [9:0] rx_slot_now = rfs_act ? 10'h000 : rx_slot_reg + 10'h001;
  wire tx_en_now = sbsp_mask_bit(tx_bit_enable_a_in, tx_bit_enable_b_in,
                                 tx_slot_now);
  wire rx_en_now = sbsp_mask_bit(rx_bit_enable_a_in, rx_bit_enable_b_in,
                                 rx_slot_now);
  wire [31:0] rx_shifted = {rx_shift_reg[30:0], din_s};
  wire [5:0] rx_bits_inc = rx_bits_reg + 6'h01;

  // ----------------------------------------------------------------
  // master sequencer: setup, clocking, hold, idle gap
  // ----------------------------------------------------------------
  assign half_next = (mst_state_reg == m_idle || tick) ?
                     8'(`SBSP_HALF_CYC - 1) : half_cnt_reg - 8'h01;
  // clock toggles only while running, else rests at its idle level
  assign sclk_pin_next = (mst_state_reg != m_run) ?
                         cfg_in.tx_clock_polarity :
                         sclk_pin_reg ^ tick;

  always_comb begin
    mst_next = mst_state_reg;
    edge_next = edge_cnt_reg;
    case (mst_state_reg)
      m_idle: begin
        edge_next = 7'h00;
        if (mst_go) begin
          mst_next = m_setup;
        end
      end
      m_setup: begin
        if (tick) begin
          mst_next = m_run;
        end
      end
      m_run: begin
        if (tick) begin
          edge_next = edge_cnt_reg + 7'h01;
          if (edge_cnt_reg == edge_last) begin
            mst_next = m_hold;
            edge_next = 7'h00;
          end
        end
      end
      m_hold: begin
        if (tick) begin
          mst_next = m_gap;
        end
      end
      m_gap: begin
        if (tick) begin
          edge_next = edge_cnt_reg + 7'h01;
          if (edge_cnt_reg == 7'(`SBSP_GAP_HALVES - 1)) begin
            mst_next = m_idle;
          end
        end
      end
      default: mst_next = m_idle;
    endcase
    if (!master) begin
      mst_next = m_idle;
    end
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  always_comb begin
    tx_shift_next = tx_shift_reg;
    tx_bits_next = tx_bits_reg;
    tx_slot_next = tx_slot_reg;
    sout_next = sout_reg;
    soe_next = 1'b0;
    tx_irq_next = 1'b0;
    fifo_pop = 1'b0;
    if (cs_on) begin
      soe_next = cs_frame;
      if (cs_start) begin
        fifo_pop = fifo_valid;
        tx_shift_next = cs_delay ? (tx_aligned << 1) : tx_aligned;
        if (cs_delay) begin
          sout_next = tx_aligned[31];
        end
      end else if (cs_frame && cs_launch) begin
        sout_next = tx_shift_reg[31];
        tx_shift_next = tx_shift_reg << 1;
      end
    end else if (pcm_on) begin
      soe_next = soe_reg;
      if (pcm_tx_ev) begin
        tx_slot_next = tx_slot_now;
        soe_next = tx_en_now;
        if (tx_en_now) begin
          if (tx_bits_reg == 4'h0) begin
            sout_next = fifo_data[15];
            tx_shift_next = {fifo_data[14:0], 17'h0_0000};
            fifo_pop = fifo_valid;
          end else begin
            sout_next = tx_shift_reg[31];
            tx_shift_next = tx_shift_reg << 1;
          end
          tx_bits_next = tx_bits_reg + 4'h1;
          tx_irq_next = (tx_bits_reg == `SBSP_PCM_LAST);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  always_comb begin
    rx_shift_next = rx_shift_reg;
    rx_bits_next = rx_bits_reg;
    rx_slot_next = rx_slot_reg;
    rx_data_next = rx_data_reg;
    rx_valid_next = 1'b0;
    if (cs_on) begin
      if (cs_start) begin
        rx_bits_next = 6'h00;
        rx_shift_next = 32'h0000_0000;
      end else if (cs_frame && cs_sample) begin
        rx_shift_next = rx_shifted;
        rx_bits_next = rx_bits_inc;
        if (rx_bits_inc == rx_len) begin
          rx_bits_next = 6'h00;
          rx_data_next = rx_shifted;
          rx_valid_next = 1'b1;
        end
      end
    end else if (pcm_on && pcm_rx_ev) begin
      rx_slot_next = rx_slot_now;
      if (rx_en_now) begin
        rx_shift_next = rx_shifted;
        rx_bits_next = rx_bits_inc;
        if (rx_bits_reg[3:0] == `SBSP_PCM_LAST) begin
          rx_bits_next = 6'h00;
          rx_data_next = {16'h0000, rx_shifted[15:0]};
          rx_valid_next = 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      mst_state_reg <= m_idle;
      half_cnt_reg <= 8'h00;
      edge_cnt_reg <= 7'h00;
      sclk_pin_reg <= 1'b0;
      cs_lvl_d_reg <= 1'b0;
    end else begin
      mst_state_reg <= mst_next;
      half_cnt_reg <= half_next;
      edge_cnt_reg <= edge_next;
      sclk_pin_reg <= sclk_pin_next;
      cs_lvl_d_reg <= cs_lvl;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      tx_shift_reg <= 32'h0000_0000;
      tx_bits_reg <= 4'h0;
      tx_slot_reg <= `SBSP_SLOT_RST;
      sout_reg <= 1'b0;
      soe_reg <= 1'b0;
      tx_irq_reg <= 1'b0;
    end else begin
      tx_shift_reg <= tx_shift_next;
      tx_bits_reg <= tx_bits_next;
      tx_slot_reg <= tx_slot_next;
      sout_reg <= sout_next;
      soe_reg <= soe_next;
      tx_irq_reg <= tx_irq_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      rx_shift_reg <= 32'h0000_0000;
      rx_bits_reg <= 6'h00;
      rx_slot_reg <= `SBSP_SLOT_RST;
      rx_data_reg <= 32'h0000_0000;
      rx_valid_reg <= 1'b0;
    end else begin
      rx_shift_reg <= rx_shift_next;
      rx_bits_reg <= rx_bits_next;
      rx_slot_reg <= rx_slot_next;
      rx_data_reg <= rx_data_next;
      rx_valid_reg <= rx_valid_next;
    end
  end

  // pin drivers: select active low, master drives clock and select
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      fs_out_reg <= 1'b1;
      fs_oe_reg <= 1'b0;
      clk_oe_reg <= 1'b0;
    end else begin
      fs_out_reg <= ~(master & (mst_next == m_setup || mst_next == m_run
                     || mst_next == m_hold));
      fs_oe_reg <= master;
      clk_oe_reg <= master;
    end
  end

  assign serial_out_pin_out = sout_reg;
  assign serial_out_pin_oe_out = soe_reg;
  assign tx_clock_pin_out = sclk_pin_reg;
  assign tx_clock_pin_oe_out = clk_oe_reg;
  assign tx_frame_sync_pin_out = fs_out_reg;
  assign tx_frame_sync_pin_oe_out = fs_oe_reg;
  assign tx_irq_out = tx_irq_reg;
  assign rx_data_word_out = rx_data_reg;
  assign rx_valid_out = rx_valid_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  a_pcm_rx_skip: assert property (
    pcm_on && pcm_rx_ev && !rx_en_now |=> $stable(rx_bits_reg) && !rx_valid_out)
    else $error("disabled receive slot was taken");
  a_pcm_rx_word: assert property (
    pcm_on && pcm_rx_ev && rx_en_now && rx_bits_reg == 6'h0f
    |=> rx_valid_out && rx_data_word_out[0] == $past(din_s))
    else $error("16th enabled bit gave no word");
  a_rx_mask_a: assert property (
    pcm_on && pcm_rx_ev && rfs_act |-> rx_en_now == rx_bit_enable_a_in[0])
    else $error("frame start not using receive pattern a");
  a_pcm_tx_hiz: assert property (
    pcm_on && pcm_tx_ev && !tx_en_now |=> !serial_out_pin_oe_out)
    else $error("disabled transmit slot driven");
  a_tx_mask_b: assert property (
    pcm_on && pcm_tx_ev && !tfs_act && tx_slot_reg == 10'h00f
    |-> tx_en_now == tx_bit_enable_b_in[0])
    else $error("slot 16 not using transmit pattern b");
  a_pcm_tx_irq: assert property (
    pcm_on && pcm_tx_ev && tx_en_now && tx_bits_reg == 4'hf |=> tx_irq_out)
    else $error("no transmit pulse after 16 bits");
  a_cs_clk_dir: assert property (
    ##1 tx_clock_pin_oe_out == $past(master))
    else $error("clock pin direction wrong");
  a_cs_launch_nodly: assert property (
    cs_on && !cs_delay && cs_frame && !cs_start && cs_lead
    |=> serial_out_pin_out == $past(tx_shift_reg[31]))
    else $error("no-delay launch not on leading edge");
  a_cs_launch_dly: assert property (
    cs_on && cs_delay && cs_frame && !cs_start && cs_trail
    |=> serial_out_pin_out == $past(tx_shift_reg[31]))
    else $error("delayed launch not on trailing edge");
  a_cs_sel_active: assert property (
    master && mst_state_reg == m_run |=> !tx_frame_sync_pin_out)
    else $error("select inactive while clocking");
  a_cs_rx_len: assert property (
    cs_on && cs_frame && !cs_start && cs_sample && rx_bits_inc == rx_len
    |=> rx_valid_out)
    else $error("packet length not honoured");
  a_cs_gap_idle: assert property (
    master && $fell(mst_frame) |=> (!mst_frame && !cs_lead)[*8])
    else $error("idle gap too short");

  c_pcm_rx_word: cover property (pcm_on && rx_valid_out);
  c_pcm_tx_irq: cover property (pcm_on && tx_irq_out);
  c_cs_master_end: cover property (master && mst_state_reg == m_hold);
  c_cs_slave_word: cover property (cs_on && !master && rx_valid_out);
endmodule

// ### sbsp_spi_slave_model.sv
// spi slave facing the port as master
// assumes clock and select come from the port pins
`timescale 1ns/1ns
module sbsp_spi_slave_model (
  input wire logic sck_in,
  input wire logic sel_n_in,
  input wire logic mosi_in,
  input wire logic cpol_in,
  input wire logic delay_in,
  input wire logic [5:0] len_in,
  input wire logic [31:0] data_in,
  output logic miso_out,
  output logic [31:0] got_out
);
  // ------------------------------------------
  // shift engine
  // ------------------------------------------
  wire logic lead = sck_in ^ cpol_in;
  int idx = 0;
  initial miso_out = 1'b0;
  // one slave only on this link, framed by its select
  // select fall starts a packet, delayed mode shows bit one early
  always @(negedge sel_n_in) begin
    got_out = 32'h0000_0000;
    idx = 0;
    if (delay_in) begin
      miso_out = data_in[len_in - 6'h01];
      idx = 1;
    end
  end
  // released line flips to the inverse of the last bit
  always @(posedge sel_n_in) miso_out = ~miso_out;
  task automatic launch();
    if (!sel_n_in && idx < len_in) begin
      miso_out = data_in[len_in - 6'h01 - 6'(idx)];
      idx++;
    end
  endtask
  task automatic grab();
    if (!sel_n_in)
      got_out = {got_out[30:0], mosi_in};
  endtask
  // leading edge samples when delayed, launches otherwise
  always @(posedge lead) if (delay_in) grab(); else launch();
  always @(negedge lead) if (delay_in) launch(); else grab();
endmodule

// ### tb.sv
// testbench: spi master in all modes, pcm frame both ways
// assumes design files and slave model compiled first
`timescale 1ns/1ns
module tb;
  import sbsp_pkg::*;
  // ------------------------------------------
  // stimulus, wiring and watchers
  // ------------------------------------------
  localparam int LENS[6] = '{8, 12, 16, 20, 24, 32};
  logic clk_in = 0, reset_n_in = 0, txv = 0, watch = 0;
  logic lk_clk = 0, lk_fs = 1, pcm_d = 0, pcm = 0;
  sbsp_cfg_s cfg = '0;
  logic [15:0] rxa = '0, rxb = '0, txa = '0, txb = '0;
  logic [31:0] txd = '0, sdat = '0, rxw, sgot, lastw = '0;
  logic [5:0] slen = 6'h08;
  logic rdy, rxv, tirq, so, so_oe, ck, ck_oe, fs, fs_oe, miso;
  wire logic sck = ck_oe ? ck : lk_clk;
  wire logic sel = fs_oe ? fs : lk_fs;
  int error_cnt = 0, checks_done = 0, cyc = 0, nrx = 0, ntx = 0;
  int gap = 0, mingap = 999, idle_bad = 0;
  always #50 clk_in = ~clk_in;
  sbsp_top u_sbsp_top (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .cfg_in(cfg), .rx_bit_enable_a_in(rxa), .rx_bit_enable_b_in(rxb),
    .tx_bit_enable_a_in(txa), .tx_bit_enable_b_in(txb),
    .tx_data_word_in(txd), .tx_valid_in(txv), .tx_ready_out(rdy),
    .rx_data_word_out(rxw), .rx_valid_out(rxv), .tx_irq_out(tirq),
    .serial_in_pin_in(pcm ? pcm_d : miso), .serial_out_pin_out(so),
    .serial_out_pin_oe_out(so_oe), .tx_clock_pin_in(sck),
    .tx_clock_pin_out(ck), .tx_clock_pin_oe_out(ck_oe),
    .tx_frame_sync_pin_in(sel), .tx_frame_sync_pin_out(fs),
    .tx_frame_sync_pin_oe_out(fs_oe), .rx_clock_pin_in(lk_clk),
    .rx_frame_sync_pin_in(lk_fs));
  sbsp_spi_slave_model u_sbsp_spi_slave_model (.sck_in(sck),
    .sel_n_in(sel), .mosi_in(so), .cpol_in(cfg.tx_clock_polarity),
    .delay_in(cfg.clock_stop_select[0]), .len_in(slen),
    .data_in(sdat), .miso_out(miso), .got_out(sgot));
  // pulse counts, select gaps, idle clock, hang limit
  always @(posedge clk_in) begin
    cyc++;
    if (rxv) begin
      nrx++;
      lastw = rxw;
    end
    if (tirq)
      ntx++;
    if (sel)
      gap++;
    else if (gap > 0) begin
      if (gap < mingap)
        mingap = gap;
      gap = 0;
    end
    if (watch && sel && ck !== 1'b0)
      idle_bad++;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic push(input logic [31:0] d);
    @(negedge clk_in);
    txd = d;
    txv = 1;
    @(negedge clk_in);
    txv = 0;
  endtask
  task automatic wait_rx(input int n);
    for (int i = 0; i < 2000 && nrx < n; i++)
      @(negedge clk_in);
  endtask
  // one packet per length, cycling the four clock schemes
  task automatic spi_modes();
    logic [31:0] w, m;
    // one phase, one word a frame, delay set by stop select
    for (int i = 0; i < 6; i++) begin
      cfg.clock_stop_select = {1'b1, i[0]};
      cfg.tx_clock_polarity = i[1];
      cfg.rx_clock_polarity = i[0];
      cfg.tx_word_length = 3'(i);
      cfg.rx_word_length = 3'(i);
      slen = 6'(LENS[i]);
      sdat = 32'hc3a5_96e1 >> i;
      w = 32'h5a3c_e187 << i;
      m = 32'hffff_ffff >> (32 - LENS[i]);
      @(negedge clk_in);
      chk({ck_oe, fs_oe}, 32'h0000_0003);
      push(w);
      wait_rx(i + 1);
      repeat (24) @(negedge clk_in);
      chk(lastw, sdat & m);
      chk(sgot, w & m);
    end
  endtask
  // two queued packets: gap and stopped clock in between
  task automatic spi_b2b();
    int n0;
    n0 = nrx;
    cfg.tx_word_length = 3'h0;
    cfg.rx_word_length = 3'h0;
    slen = 6'h08;
    watch = 1;
    push(32'h0000_00a5);
    push(32'h0000_003c);
    wait_rx(n0 + 2);
    repeat (24) @(negedge clk_in);
    watch = 0;
    chk(sgot, 32'h0000_003c);
    chk(lastw, sdat & 32'h0000_00ff);
    chk(32'(mingap >= 16), 32'h0000_0001);
    chk(idle_bad, 32'h0000_0000);
  endtask
  // port as slave, bench as master: one 8-bit packet each way
  task automatic spi_slave();
    logic [7:0] mo, got;
    int n0;
    n0 = nrx;
    mo = 8'h36;
    got = 8'h00;
    cfg = '{1'b0, 2'b10, 1'b0, 1'b0, 1'b0, 3'h0, 3'h0};
    pcm = 1;
    push(32'h0000_00c9);
    chk({ck_oe, fs_oe}, 32'h0000_0000);
    lk_fs = 0;
    repeat (8) @(negedge clk_in);
    for (int b = 7; b >= 0; b--) begin
      pcm_d = mo[b];
      lk_clk = 1;
      repeat (8) @(negedge clk_in);
      got[b] = so;
      lk_clk = 0;
      repeat (8) @(negedge clk_in);
    end
    chk(so_oe, 32'h0000_0001);
    lk_fs = 1;
    repeat (8) @(negedge clk_in);
    chk(32'(got), 32'h0000_00c9);
    chk(lastw, 32'h0000_0036);
    chk(nrx - n0, 32'h0000_0001);
  endtask
  // one 32-slot frame each way; fifo filled until it refuses
  task automatic pcm_frame();
    logic [15:0] re, te;
    logic [31:0] pin, rm, tm;
    int n0;
    n0 = nrx;
    re = 16'h0000;
    te = 16'h69f4;
    pin = 32'hb535_76db;
    cfg = '{1'b1, 2'b00, 1'b0, 1'b0, 1'b0, 3'h2, 3'h2};
    {rxb, rxa, txb, txa} = 64'he4e4_aaaa_318c_e63e;
    rm = {rxb, rxa};
    tm = {txb, txa};
    pcm = 1;
    for (int i = 0; i < 8; i++)
      push(i == 0 ? 32'(te) : 32'(i));
    chk(rdy, 32'h0000_0000);
    chk({ck_oe, fs_oe}, 32'h0000_0000);
    for (int s = 0; s < 32; s++) begin
      lk_fs = (s != 0);
      pcm_d = pin[31 - s];
      lk_clk = 1;
      repeat (4) @(negedge clk_in);
      chk(so_oe, tm[s]);
      if (tm[s]) begin
        chk(so, te[15]);
        te = te << 1;
      end
      if (rm[s])
        re = {re[14:0], pin[31 - s]};
      lk_clk = 0;
      repeat (4) @(negedge clk_in);
    end
    lk_fs = 1;
    repeat (8) @(negedge clk_in);
    chk(lastw, {16'h0000, re});
    chk(nrx - n0, 32'h0000_0001);
    chk(ntx, 32'h0000_0001);
    chk(rdy, 32'h0000_0001);
  endtask
  initial begin
    cfg.tx_clock_direction = 1;
    repeat (12) @(negedge clk_in);
    reset_n_in = 1;
    repeat (2) @(negedge clk_in);
    spi_modes();
    spi_b2b();
    spi_slave();
    pcm_frame();
    results();
  end
endmodule
